// ==== verilog/event_latch_pkg.sv ====
// Package: offsets, field positions, reset values and timing of the event latches
package event_latch_pkg;

  localparam logic [7:0] SOFT_RESET_OFFSET   = 8'h18;
  localparam logic [7:0] TOP_SUMMARY_OFFSET  = 8'h19;
  localparam logic [7:0] RESET_EVENT_OFFSET  = 8'h1a;
  localparam logic [7:0] BUCK_EVENT_OFFSET   = 8'h1b;
  localparam logic [7:0] LINEAR_EVENT_OFFSET = 8'h1c;

  localparam logic [7:0] REG_RESET_VALUE     = 8'h00;
  localparam logic [7:0] REG_ZERO            = 8'h00;

  localparam int RESET_EVENT_BIT    = 0;
  localparam int SOFT_RESET_BIT     = 0;
  localparam int BUCK_SUMMARY_BIT   = 5;
  localparam int LINEAR_SUMMARY_BIT = 6;

  localparam int SECOND_PG_BIT      = 6;
  localparam int SECOND_SHORT_BIT   = 5;
  localparam int SECOND_ILIM_BIT    = 4;
  localparam int FIRST_PG_BIT       = 2;
  localparam int FIRST_SHORT_BIT    = 1;
  localparam int FIRST_ILIM_BIT     = 0;

  localparam logic [7:0] RESET_EVENT_MASK = 8'h01;
  localparam logic [7:0] EVENT_MASK       = 8'h77;

  localparam int CLK_MHZ          = 100;
  localparam int SHORT_TIME_US    = 1000;
  localparam int SHORT_CYCLES     = SHORT_TIME_US * CLK_MHZ;
  localparam int SHORT_CNT_WIDTH  = 17;

  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_STARTUP  = 2'b10
  } power_state_e;

endpackage

// ==== verilog/event_sync.sv ====
// Two-stage synchroniser with rising-edge pulse for a group of event lines
`timescale 1ns/1ps
module event_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] prev_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg  <= '0;
      level_reg <= '0;
      prev_reg  <= '0;
    end else begin
      meta_reg  <= async_in;
      level_reg <= meta_reg;
      prev_reg  <= level_reg;
    end
  end

  assign level = level_reg;
  assign rise  = level_reg & ~prev_reg;

endmodule

// ==== verilog/short_timer.sv ====
// Qualifies a short-circuit level that must persist beyond a set time
`timescale 1ns/1ps
module short_timer #(
  parameter int LIMIT = event_latch_pkg::SHORT_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic below,
  output logic      fire
);

  localparam logic [event_latch_pkg::SHORT_CNT_WIDTH-1:0] LIMIT_W =
    event_latch_pkg::SHORT_CNT_WIDTH'(LIMIT);

  logic [event_latch_pkg::SHORT_CNT_WIDTH-1:0] cnt_reg;
  logic [event_latch_pkg::SHORT_CNT_WIDTH-1:0] cnt_next;
  logic                                        done_reg;
  logic                                        fire_reg;
  wire                                         reached;

  // Counter stops at the limit; done_reg keeps one episode to one pulse
  assign reached  = below && (cnt_reg == LIMIT_W) && !done_reg;
  assign cnt_next = !below ? '0 : (cnt_reg == LIMIT_W) ? cnt_reg : cnt_reg + 1'b1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
      fire_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= below && (done_reg || reached);
      fire_reg <= reached;
    end
  end

  assign fire = fire_reg;

endmodule

// ==== verilog/regulator_event_latches.sv ====
// Latched event registers for bucks, linear regulators and device reset
//
// Overview of operation
// RL1: Reset-event bit 0 at 0x1a sets on supply undervoltage or software reset; code sets it only while running, not on a dip during startup.
// RL2: Reset event disables regulators, defaults registers, runs startup, leaves flag set.
// RL3: Reset-event flag stays until host writes one; bits 7:1 read zero.
// RL4: Buck register 0x1b: second buck bits 6,5,4, first bits 2,1,0.
// RL5: Second buck power-good latch sets on its power-good event.
// RL6: First buck power-good latch sets on its power-good event.
// RL7: Buck short latch sets only after output low over 1 ms continuously.
// RL8: Buck current-limit latch sets when its current limit becomes active.
// RL9: Event latches hold until written one; zero writes ignored; default zero.
// RL10: Linear register 0x1c mirrors buck layout; bits 7 and 3 reserved.
// RL11: Linear power-good latch sets on that regulator's power-good event.
// RL12: Linear short latch sets after output low over 1 ms.
// RL13: Linear current-limit latch sets when its current limit has been active.
// RL14: Summary bits set while event register nonzero, clear when it returns zero.
// RL15: Software reset command bit clears itself once the reset starts.
// RL16: Event and clear in the same cycle leave the bit set.
// RL17: Asynchronous event sources are synchronised and latched on rising indication.
`timescale 1ns/1ps
module regulator_event_latches #(
  parameter int SHORT_LIMIT = event_latch_pkg::SHORT_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  input  wire logic       analog_supply_low,
  input  wire logic [1:0] buck_power_good_event,
  input  wire logic [1:0] buck_below_short,
  input  wire logic [1:0] buck_current_limit,
  input  wire logic [1:0] linear_power_good_event,
  input  wire logic [1:0] linear_below_short,
  input  wire logic [1:0] linear_current_limit,
  input  wire logic       startup_done,
  output logic            regulators_disable,
  output logic            startup_start,
  output logic            buck_summary_flag,
  output logic            linear_summary_flag
);

  // Packs per-regulator events into the shared register layout
  function automatic logic [7:0] pack_events(
    input logic [1:0] pg,
    input logic [1:0] sc,
    input logic [1:0] il
  );
    logic [7:0] v;
    v = event_latch_pkg::REG_ZERO;
    v[event_latch_pkg::SECOND_PG_BIT]    = pg[1];
    v[event_latch_pkg::SECOND_SHORT_BIT] = sc[1];
    v[event_latch_pkg::SECOND_ILIM_BIT]  = il[1];
    v[event_latch_pkg::FIRST_PG_BIT]     = pg[0];
    v[event_latch_pkg::FIRST_SHORT_BIT]  = sc[0];
    v[event_latch_pkg::FIRST_ILIM_BIT]   = il[0];
    return v;
  endfunction

  // Write-one-to-clear with set priority
  function automatic logic [7:0] w1c_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic       hit,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    logic [7:0] clr;
    clr = hit ? wdata : event_latch_pkg::REG_ZERO;
    return ((cur & ~clr) | set) & mask;
  endfunction

  // Synchronised event sources
  logic       uv_level;
  logic [1:0] buck_pg_rise;
  logic [1:0] buck_sc_level;
  logic [1:0] buck_il_rise;
  logic [1:0] lin_pg_rise;
  logic [1:0] lin_sc_level;
  logic [1:0] lin_il_rise;
  logic [1:0] buck_sc_fire;
  logic [1:0] lin_sc_fire;

  event_sync #(.WIDTH(1)) u_uv_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (analog_supply_low),
    .level    (uv_level),
    .rise     ()
  ); // see RL17

  event_sync #(.WIDTH(2)) u_buck_pg_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (buck_power_good_event),
    .level    (),
    .rise     (buck_pg_rise)
  ); // see RL17

  event_sync #(.WIDTH(2)) u_buck_sc_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (buck_below_short),
    .level    (buck_sc_level),
    .rise     ()
  );

  event_sync #(.WIDTH(2)) u_buck_il_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (buck_current_limit),
    .level    (),
    .rise     (buck_il_rise)
  );

  event_sync #(.WIDTH(2)) u_lin_pg_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (linear_power_good_event),
    .level    (),
    .rise     (lin_pg_rise)
  );

  event_sync #(.WIDTH(2)) u_lin_sc_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (linear_below_short),
    .level    (lin_sc_level),
    .rise     ()
  );

  event_sync #(.WIDTH(2)) u_lin_il_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (linear_current_limit),
    .level    (),
    .rise     (lin_il_rise)
  );

  // One qualifying timer per output
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_short
      short_timer #(.LIMIT(SHORT_LIMIT)) u_buck_short (
        .ref_clk (ref_clk),
        .rst     (rst),
        .below   (buck_sc_level[gi]),
        .fire    (buck_sc_fire[gi])
      ); // see RL7
      short_timer #(.LIMIT(SHORT_LIMIT)) u_lin_short (
        .ref_clk (ref_clk),
        .rst     (rst),
        .below   (lin_sc_level[gi]),
        .fire    (lin_sc_fire[gi])
      ); // see RL12
    end
  endgenerate

  // Registers and state
  event_latch_pkg::power_state_e state_reg;
  event_latch_pkg::power_state_e state_next;
  logic [7:0] software_reset_command_reg;
  logic [7:0] reset_event_reg;
  logic [7:0] buck_event_reg;
  logic [7:0] linear_event_reg;
  logic [7:0] rd_data_reg;
  logic       disable_reg;
  logic       startup_reg;
  logic       buck_sum_reg;
  logic       lin_sum_reg;

  wire        running;
  wire        reset_trigger;
  wire        enter_shutdown;
  wire        wr_soft_reset;
  wire        wr_reset_event;
  wire        wr_buck;
  wire        wr_linear;
  wire  [7:0] buck_set;
  wire  [7:0] linear_set;
  wire  [7:0] reset_set;
  wire  [7:0] software_reset_command_next;
  wire  [7:0] reset_event_next;
  wire  [7:0] buck_event_next;
  wire  [7:0] linear_event_next;
  wire  [7:0] summary_value;
  wire  [7:0] rd_mux;

  assign running        = (state_reg == event_latch_pkg::ST_RUN);
  assign reset_trigger  = uv_level || software_reset_command_reg[event_latch_pkg::SOFT_RESET_BIT]; // see RL1
  assign enter_shutdown = running && reset_trigger;

  // Soft-reset and event writes only land while running; a reset in progress owns those registers
  // Reset flag stays clearable in any state so the host can acknowledge early
  assign wr_soft_reset  = running && reg_wr_en && (reg_addr == event_latch_pkg::SOFT_RESET_OFFSET);
  assign wr_reset_event = reg_wr_en && (reg_addr == event_latch_pkg::RESET_EVENT_OFFSET);
  assign wr_buck        = running && reg_wr_en && (reg_addr == event_latch_pkg::BUCK_EVENT_OFFSET);
  assign wr_linear      = running && reg_wr_en && (reg_addr == event_latch_pkg::LINEAR_EVENT_OFFSET);

  assign buck_set   = pack_events(buck_pg_rise, buck_sc_fire, buck_il_rise); // see RL4, RL5, RL6, RL8
  assign linear_set = pack_events(lin_pg_rise, lin_sc_fire, lin_il_rise); // see RL10, RL11, RL13
  assign reset_set  = enter_shutdown ? event_latch_pkg::RESET_EVENT_MASK : event_latch_pkg::REG_ZERO;

  // Command bit drops as soon as the shutdown starts
  assign software_reset_command_next = !running ? event_latch_pkg::REG_RESET_VALUE :
                                       enter_shutdown ? event_latch_pkg::REG_RESET_VALUE :
                                       wr_soft_reset ? (reg_wr_data & event_latch_pkg::RESET_EVENT_MASK) :
                                       software_reset_command_reg; // see RL15

  // Flag survives the reset it reports; set wins over a same-cycle clear
  assign reset_event_next = w1c_next(reset_event_reg, reset_set, wr_reset_event,
                                     reg_wr_data, event_latch_pkg::RESET_EVENT_MASK); // see RL3, RL16

  // Defaults restored for the whole shutdown
  assign buck_event_next   = !running || enter_shutdown ? event_latch_pkg::REG_RESET_VALUE :
                             w1c_next(buck_event_reg, buck_set, wr_buck,
                                      reg_wr_data, event_latch_pkg::EVENT_MASK); // see RL2, RL9, RL16
  assign linear_event_next = !running || enter_shutdown ? event_latch_pkg::REG_RESET_VALUE :
                             w1c_next(linear_event_reg, linear_set, wr_linear,
                                      reg_wr_data, event_latch_pkg::EVENT_MASK); // see RL2, RL9, RL16

  // Power sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      event_latch_pkg::ST_RUN: begin
        if (reset_trigger) begin
          state_next = event_latch_pkg::ST_SHUTDOWN; // see RL2
        end
      end
      event_latch_pkg::ST_SHUTDOWN: begin
        if (!uv_level) begin
          state_next = event_latch_pkg::ST_STARTUP;
        end
      end
      event_latch_pkg::ST_STARTUP: begin
        // A supply dip mid-startup goes back to shutdown
        if (uv_level) begin
          state_next = event_latch_pkg::ST_SHUTDOWN;
        end else if (startup_done) begin
          state_next = event_latch_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = event_latch_pkg::ST_SHUTDOWN;
      end
    endcase
  end

  // Summary bits follow the registers directly; the summary flag outputs follow one cycle later
  assign summary_value = {1'b0, (linear_event_reg != event_latch_pkg::REG_ZERO),
                          (buck_event_reg != event_latch_pkg::REG_ZERO), 5'h00}; // see RL14

  assign rd_mux = (reg_addr == event_latch_pkg::SOFT_RESET_OFFSET)   ? software_reset_command_reg :
                  (reg_addr == event_latch_pkg::TOP_SUMMARY_OFFSET)  ? summary_value :
                  (reg_addr == event_latch_pkg::RESET_EVENT_OFFSET)  ? reset_event_reg :
                  (reg_addr == event_latch_pkg::BUCK_EVENT_OFFSET)   ? buck_event_reg :
                  (reg_addr == event_latch_pkg::LINEAR_EVENT_OFFSET) ? linear_event_reg :
                  event_latch_pkg::REG_ZERO;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg        <= event_latch_pkg::ST_RUN;
      software_reset_command_reg <= event_latch_pkg::REG_RESET_VALUE;
      reset_event_reg  <= event_latch_pkg::REG_RESET_VALUE;
      buck_event_reg   <= event_latch_pkg::REG_RESET_VALUE;
      linear_event_reg <= event_latch_pkg::REG_RESET_VALUE;
    end else begin
      state_reg        <= state_next;
      software_reset_command_reg <= software_reset_command_next;
      reset_event_reg  <= reset_event_next;
      buck_event_reg   <= buck_event_next;
      linear_event_reg <= linear_event_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_reg  <= event_latch_pkg::REG_ZERO;
      disable_reg  <= 1'b0;
      startup_reg  <= 1'b0;
      buck_sum_reg <= 1'b0;
      lin_sum_reg  <= 1'b0;
    end else begin
      rd_data_reg  <= reg_rd_en ? rd_mux : rd_data_reg;
      disable_reg  <= (state_next == event_latch_pkg::ST_SHUTDOWN); // see RL2
      startup_reg  <= (state_next == event_latch_pkg::ST_STARTUP);
      buck_sum_reg <= summary_value[event_latch_pkg::BUCK_SUMMARY_BIT]; // see RL14
      lin_sum_reg  <= summary_value[event_latch_pkg::LINEAR_SUMMARY_BIT];
    end
  end

  assign reg_rd_data         = rd_data_reg;
  assign regulators_disable  = disable_reg;
  assign startup_start       = startup_reg;
  assign buck_summary_flag   = buck_sum_reg;
  assign linear_summary_flag = lin_sum_reg;

endmodule

// ==== tb/startup_responder.sv ====
// Model of the startup sequencer that answers the startup request
`timescale 1ns/1ps
module startup_responder (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       startup_start,
  input  wire logic [7:0] delay,
  output logic            startup_done
);
  logic [7:0] wait_reg;

  // One-cycle done pulse after the chosen delay; delay 0 answers promptly
  always_ff @(posedge ref_clk) begin
    startup_done <= 1'b0;
    if (rst || !startup_start || startup_done) begin
      wait_reg <= 8'h00;
    end else if (wait_reg >= delay) begin
      startup_done <= 1'b1;
      wait_reg     <= 8'h00;
    end else begin
      wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule

// ==== tb/regulator_event_latches_props.sv ====
// Checker of reads, event latching and reset sequencing at the block ports
`timescale 1ns/1ps
module regulator_event_latches_props #(
  parameter int SHORT_LIMIT = 20
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       analog_supply_low,
  input wire logic [1:0] buck_current_limit,
  input wire logic [1:0] linear_power_good_event,
  input wire logic       startup_done,
  input wire logic       regulators_disable,
  input wire logic       startup_start,
  input wire logic       buck_summary_flag,
  input wire logic       linear_summary_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire unmapped = reg_addr < 8'h18 || reg_addr > 8'h1c;
  // Quiet means the latch path is free of shutdown and host writes
  wire quiet = !regulators_disable && !startup_start && !analog_supply_low && !reg_wr_en;

  a_unmapped_zero: assert property (
    reg_rd_en && unmapped |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
  a_buck_reserved: assert property (
    reg_rd_en && reg_addr == 8'h1b |=> !reg_rd_data[7] && !reg_rd_data[3]) else $error("buck reserved set");
  a_linear_reserved: assert property (
    reg_rd_en && reg_addr == 8'h1c |=> !reg_rd_data[7] && !reg_rd_data[3]) else $error("linear reserved set");
  a_reset_reserved: assert property (
    reg_rd_en && reg_addr == 8'h1a |=> reg_rd_data[7:1] == 7'h00) else $error("reset reserved set");
  a_uv_disables: assert property (
    analog_supply_low [*8] |-> regulators_disable) else $error("no shutdown on undervoltage");
  a_shutdown_then_start: assert property (
    $fell(regulators_disable) && !$past(rst) |-> startup_start) else $error("no startup after shutdown");
  a_start_ends: assert property (
    startup_start && startup_done && !analog_supply_low |=> !startup_start) else $error("startup not ended");
  a_shutdown_clears: assert property (
    regulators_disable [*3] |-> !buck_summary_flag && !linear_summary_flag) else $error("summary kept");
  a_buck_event_flags: assert property (
    $rose(buck_current_limit[0]) ##0 quiet [*7] |-> buck_summary_flag) else $error("buck event lost");
  a_linear_event_flags: assert property (
    $rose(linear_power_good_event[1]) ##0 quiet [*7] |-> linear_summary_flag) else $error("linear event lost");
endmodule

bind regulator_event_latches regulator_event_latches_props #(.SHORT_LIMIT(SHORT_LIMIT)) props_u (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .analog_supply_low(analog_supply_low), .buck_current_limit(buck_current_limit),
  .linear_power_good_event(linear_power_good_event), .startup_done(startup_done),
  .regulators_disable(regulators_disable), .startup_start(startup_start),
  .buck_summary_flag(buck_summary_flag), .linear_summary_flag(linear_summary_flag));

// ==== tb/regulator_event_latches_tb_top.sv ====
// Register-level testbench of the regulator event latches
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module regulator_event_latches_tb_top;
  logic       ref_clk, rst, reg_wr_en, reg_rd_en, analog_supply_low, startup_done;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, delay;
  logic [1:0] bpg, bbs, bcl, lpg, lbs, lcl;
  logic       regulators_disable, startup_start, buck_summary_flag, linear_summary_flag;
  int         fail_count, checks_done;
  logic [7:0] idle_addr [6] = '{8'h1a, 8'h1b, 8'h1c, 8'h18, 8'h19, 8'h55};

  // Short limit cut down so a qualifying episode is tens of cycles
  regulator_event_latches #(.SHORT_LIMIT(20)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .analog_supply_low(analog_supply_low), .buck_power_good_event(bpg), .buck_below_short(bbs),
    .buck_current_limit(bcl), .linear_power_good_event(lpg), .linear_below_short(lbs),
    .linear_current_limit(lcl), .startup_done(startup_done), .regulators_disable(regulators_disable),
    .startup_start(startup_start), .buck_summary_flag(buck_summary_flag),
    .linear_summary_flag(linear_summary_flag));

  startup_responder partner_u (.ref_clk(ref_clk), .rst(rst), .startup_start(startup_start),
    .delay(delay), .startup_done(startup_done));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wt(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd_en = 1'b0;
    `CHK($sformatf("register %h", a), e, reg_rd_data)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bounded wait on disable (0) or startup (1); running out ends the run as a failure
  task automatic wait_for(input int which, input logic v);
    int   i;
    logic seen;
    i = 0;
    seen = (which == 0) ? regulators_disable : startup_start;
    while (seen !== v && i < 300) begin
      cyc(1);
      i++;
      seen = (which == 0) ? regulators_disable : startup_start;
    end
    if (seen !== v) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", (which == 0) ? "disable" : "startup", v, seen);
      results();
    end
  endtask

  initial begin
    {reg_wr_en, reg_rd_en, analog_supply_low, reg_addr, reg_wr_data} = '0;
    {bpg, bbs, bcl, lpg, lbs, lcl} = '0;
    delay = 8'h02;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    cyc(2);
    foreach (idle_addr[i]) rd(idle_addr[i], 8'h00);
    {bpg, bcl, lpg, lcl} = 8'hff;
    cyc(6);
    {bpg, bcl, lpg, lcl} = 8'h00;
    cyc(2);
    rd(8'h1b, 8'h55);
    rd(8'h1c, 8'h55);
    rd(8'h19, 8'h60);
    `CHK("buck summary", 1'b1, buck_summary_flag)
    `CHK("linear summary", 1'b1, linear_summary_flag)
    wt(8'h1b, 8'h00);
    rd(8'h1b, 8'h55);
    wt(8'h1b, 8'h04);
    rd(8'h1b, 8'h51);
    wt(8'h1b, 8'hff);
    wt(8'h1c, 8'hff);
    cyc(2);
    rd(8'h1b, 8'h00);
    `CHK("summary", 1'b0, buck_summary_flag | linear_summary_flag)
    // Second buck limit latches in the very cycle its bit is written one
    bcl = 2'b10;
    cyc(1);
    wt(8'h1b, 8'h10);
    rd(8'h1b, 8'h10);
    wt(8'h1b, 8'h10);
    bcl = 2'b00;
    // A dip shorter than the limit must not latch
    {bbs, lbs} = 4'hf;
    cyc(10);
    {bbs, lbs} = 4'h0;
    cyc(30);
    rd(8'h1b, 8'h00);
    rd(8'h1c, 8'h00);
    {bbs, lbs} = 4'hf;
    cyc(40);
    rd(8'h1b, 8'h22);
    rd(8'h1c, 8'h22);
    wt(8'h1b, 8'hff);
    cyc(5);
    rd(8'h1b, 8'h00);
    {bbs, lbs} = 4'h0;
    wt(8'h1c, 8'hff);
    bcl = 2'b01;
    cyc(6);
    bcl = 2'b00;
    analog_supply_low = 1'b1;
    wait_for(0, 1'b1);
    cyc(3);
    rd(8'h1b, 8'h00);
    rd(8'h1a, 8'h01);
    analog_supply_low = 1'b0;
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    cyc(2);
    rd(8'h1a, 8'h01);
    wt(8'h1a, 8'hfe);
    rd(8'h1a, 8'h01);
    wt(8'h1a, 8'hff);
    rd(8'h1a, 8'h00);
    // Slow partner this time
    delay = 8'h30;
    wt(8'h18, 8'h01);
    wait_for(1, 1'b1);
    // Supply dip during startup goes back to shutdown
    analog_supply_low = 1'b1;
    wait_for(0, 1'b1);
    `CHK("startup", 1'b0, startup_start)
    analog_supply_low = 1'b0;
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    cyc(2);
    rd(8'h18, 8'h00);
    rd(8'h1a, 8'h01);
    results();
  end
endmodule
